// *** hdl/temp_monitor_params.svh ***
// Register addresses, field positions, reset values and timing constants
`ifndef TEMP_MONITOR_PARAMS_SVH
`define TEMP_MONITOR_PARAMS_SVH
// ----------------------------------------------------------------------
// Register addresses (read and write)
// ----------------------------------------------------------------------
`define A_LOCAL_T     8'h00
`define A_RMT_T_HI    8'h01
`define A_STATUS      8'h02
`define A_CFG_RD      8'h03
`define A_RATE_RD     8'h04
`define A_LHL_RD      8'h05
`define A_LLL_RD      8'h06
`define A_RHLU_RD     8'h07
`define A_RLLU_RD     8'h08
`define A_CFG_WR      8'h09
`define A_RATE_WR     8'h0A
`define A_LHL_WR      8'h0B
`define A_LLL_WR      8'h0C
`define A_RHLU_WR     8'h0D
`define A_RLLU_WR     8'h0E
`define A_ONE_SHOT    8'h0F
`define A_RMT_T_LO    8'h10
`define A_OFS_HI      8'h11
`define A_OFS_LO      8'h12
`define A_RHLL        8'h13
`define A_RLLL        8'h14
`define A_RCRIT       8'h19
`define A_LCRIT       8'h20
`define A_HYST        8'h21
`define A_CONSEC      8'h22
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ST_BUSY       7
`define ST_RCRIT      1
`define ST_LCRIT      0
`define CFG_MASK      7
`define CFG_STBY      6
`define CFG_PIN8      5
`define CFG_RSVD3     3
`define CA_SCL        7
`define CA_SDA        6
// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_CFG       8'h08
`define RST_RATE      4'h6
`define RST_HIGH      8'h55
`define RST_CRIT      8'h55
`define RST_HYST      8'h0A
`define RST_FQ        4'h1
`define RST_ZERO      8'h00
`define RATE_MAX      4'hA
// ----------------------------------------------------------------------
// Timing: conversion periods in ms, bus timeout in ms
// ----------------------------------------------------------------------
`define MCLK_HZ       50000000
`define MS_PER_S      1000
`define CYC_PER_MS    (`MCLK_HZ / `MS_PER_S)
`define TIMEOUT_MS    30
`define PER_0         14'd16000
`define PER_1         14'd8000
`define PER_2         14'd4000
`define PER_3         14'd2000
`define PER_4         14'd1000
`define PER_5         14'd500
`define PER_6         14'd250
`define PER_7         14'd200
`define PER_8         14'd100
`define PER_9         14'd50
`define PER_10        14'd27
`endif

// *** hdl/temp_monitor_pkg.sv ***
// Types shared by the temperature monitor register bank
package temp_monitor_pkg;
   // Converter sequencing
   typedef enum logic {CONV_IDLE, CONV_RUN} conv_e;

   // Whole state of the register bank
   typedef struct packed {
      logic [7:0]        cfg;
      logic [3:0]        rate;
      logic [7:0]        lhl, lll, rhlu, rllu, rhll, rlll;
      logic [7:0]        ofs_hi, ofs_lo, rcrit, lcrit, hyst;
      logic              scl_to, sda_to;
      logic [3:0]        fq;
      logic [7:0]        local_t, rmt_hi, rmt_lo;
      logic              open_now;
      logic [4:0]        lflags;
      logic              lcrit_act, rcrit_act;
      logic [4:0][2:0]   qcnt;
      logic              eval;
      conv_e             conv;
      logic [13:0]       ms_left;
      logic [31:0]       tick;
      logic [1:0][1:0]   sync;
      logic [1:0][31:0]  to_cnt;
      logic [7:0]        rdata;
      logic              conv_start, bus_rst, alert, pin8_low, crit_out;
   } bank_s;
endpackage : temp_monitor_pkg

// *** hdl/temp_monitor_regs.sv ***
// Register bank, conversion pacing and status logic of the temperature monitor
//
// Behaviour
// RULE1: rate code low nibble picks conversions per second
// RULE2: conversions spaced by the code's period
// RULE3: rate read at 0x04, written at 0x0A
// RULE4: status bit 7 busy, never alerts
// RULE5: on-chip over/under limit bits 6, 5
// RULE6: remote over/under limit bits 4, 3
// RULE7: open remote sensor sets bit 2
// RULE8: critical bits 1, 0, no alert
// RULE9: bits 6..2 latched until status read
// RULE10: bit 7 enables clock-line timeout
// RULE11: bit 6 enables data-line timeout
// RULE12: fault queue sets consecutive count needed
// RULE13: consecutive register at 0x22, bits 5,4 reserved
// RULE14: result registers read-only, zero at reset
// RULE15: limit highs read 05-08, written 0B-0E
// RULE16: power-on limit and hysteresis values
// RULE17: remote offset at 11 and 12
// RULE18: critical limits and hysteresis 19, 20, 21
// RULE19: mask bit suppresses alert output
// RULE20: standby stops conversions, outputs still update
// RULE21: stuck bus line resets serial interface
`timescale 1ns/10ps
`include "temp_monitor_params.svh"

module temp_monitor_regs
   import temp_monitor_pkg::*;
#(
   parameter int unsigned CYC_PER_MS     = `CYC_PER_MS,             // Cycles per millisecond
   parameter int unsigned TIMEOUT_CYCLES = `TIMEOUT_MS * `CYC_PER_MS // Stuck-line limit
) (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // Register access from the serial interface
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // Measurement front end
   output logic            conv_start,
   input  wire logic       meas_done,
   input  wire logic [7:0] meas_local,
   input  wire logic [9:0] meas_remote,
   input  wire logic       meas_open,
   // Bus lines, for timeout watch
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            bus_rst,
   // Alarm outputs
   output logic            alert_out,
   output logic            pin8_low,
   output logic            critical_temp_output
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   bank_s st_r;                         // Registered state
   bank_s st_nxt;                       // Next state
   logic [4:0] cond;                    // Out-of-limit conditions, bit 4 = on-chip high
   logic [4:0] set_vec;                 // Flag set requests this cycle
   logic [2:0] need;                    // Consecutive measurements required
   logic [9:0] rmt10;                   // Remote reading, 10 bits
   logic       stby;                    // Standby selected

   localparam bank_s ST_RESET = '{
      cfg: `RST_CFG, rate: `RST_RATE, lhl: `RST_HIGH, lll: `RST_ZERO,
      rhlu: `RST_HIGH, rllu: `RST_ZERO, rhll: `RST_ZERO, rlll: `RST_ZERO,
      ofs_hi: `RST_ZERO, ofs_lo: `RST_ZERO, rcrit: `RST_CRIT, lcrit: `RST_CRIT,
      hyst: `RST_HYST, fq: `RST_FQ, local_t: `RST_ZERO, rmt_hi: `RST_ZERO,
      rmt_lo: `RST_ZERO, conv: CONV_IDLE, rdata: `RST_ZERO, default: '0};

   // Period in ms for a rate code; codes above the table run fastest
   function automatic logic [13:0] period_ms(input logic [3:0] code);
      case (code)
         4'h0:    period_ms = `PER_0;
         4'h1:    period_ms = `PER_1;
         4'h2:    period_ms = `PER_2;
         4'h3:    period_ms = `PER_3;
         4'h4:    period_ms = `PER_4;
         4'h5:    period_ms = `PER_5;
         4'h6:    period_ms = `PER_6;
         4'h7:    period_ms = `PER_7;
         4'h8:    period_ms = `PER_8;
         4'h9:    period_ms = `PER_9;
         default: period_ms = `PER_10;
      endcase
   endfunction : period_ms

   // ----------------------------------------------------------------------
   // Limit comparison, evaluated every cycle so standby edits take hold
   // ----------------------------------------------------------------------
   always_comb begin
      stby    = st_r.cfg[`CFG_STBY];
      rmt10   = {st_r.rmt_hi, st_r.rmt_lo[7:6]};
      cond[4] = st_r.local_t > st_r.lhl;                          // RULE5
      cond[3] = st_r.local_t < st_r.lll;                          // RULE5
      cond[2] = rmt10 > {st_r.rhlu, st_r.rhll[7:6]};              // RULE6
      cond[1] = rmt10 < {st_r.rllu, st_r.rlll[7:6]};              // RULE6
      cond[0] = st_r.open_now;                                    // RULE7
      // Bit 0 of the queue field is ignored
      if (st_r.fq[3]) begin
         need = 3'd4;                                             // RULE12
      end else if (st_r.fq[2]) begin
         need = 3'd3;
      end else if (st_r.fq[1]) begin
         need = 3'd2;
      end else begin
         need = 3'd1;
      end
   end

   // ----------------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------------
   always_comb begin
      st_nxt            = st_r;
      st_nxt.conv_start = 1'b0;
      st_nxt.bus_rst    = 1'b0;
      st_nxt.eval       = 1'b0;

      // Register writes; read-only and read-side addresses are ignored
      if (reg_wr) begin
         if (reg_addr == `A_CFG_WR) begin
            st_nxt.cfg = {reg_wdata[7:4], 1'b1, reg_wdata[2], 2'b00};
         end else if (reg_addr == `A_RATE_WR) begin
            st_nxt.rate = reg_wdata[3:0];                         // RULE3
         end else if (reg_addr == `A_LHL_WR) begin
            st_nxt.lhl = reg_wdata;                               // RULE15
         end else if (reg_addr == `A_LLL_WR) begin
            st_nxt.lll = reg_wdata;                               // RULE15
         end else if (reg_addr == `A_RHLU_WR) begin
            st_nxt.rhlu = reg_wdata;                              // RULE15
         end else if (reg_addr == `A_RLLU_WR) begin
            st_nxt.rllu = reg_wdata;                              // RULE15
         end else if (reg_addr == `A_OFS_HI) begin
            st_nxt.ofs_hi = reg_wdata;                            // RULE17
         end else if (reg_addr == `A_OFS_LO) begin
            st_nxt.ofs_lo = reg_wdata;                            // RULE17
         end else if (reg_addr == `A_RHLL) begin
            st_nxt.rhll = reg_wdata;                              // RULE15
         end else if (reg_addr == `A_RLLL) begin
            st_nxt.rlll = reg_wdata;                              // RULE15
         end else if (reg_addr == `A_RCRIT) begin
            st_nxt.rcrit = reg_wdata;                             // RULE18
         end else if (reg_addr == `A_LCRIT) begin
            st_nxt.lcrit = reg_wdata;                             // RULE18
         end else if (reg_addr == `A_HYST) begin
            st_nxt.hyst = reg_wdata;                              // RULE18
         end else if (reg_addr == `A_CONSEC) begin
            st_nxt.scl_to = reg_wdata[`CA_SCL];                   // RULE13
            st_nxt.sda_to = reg_wdata[`CA_SDA];
            st_nxt.fq     = reg_wdata[3:0];
         end
      end

      // Millisecond tick and period countdown
      if (st_r.tick == CYC_PER_MS - 1) begin
         st_nxt.tick = '0;
         if (st_r.ms_left != '0) begin
            st_nxt.ms_left = st_r.ms_left - 14'd1;
         end
      end else begin
         st_nxt.tick = st_r.tick + 32'd1;
      end

      // Conversion sequencing
      case (st_r.conv)
         CONV_IDLE: begin
            // Standby holds off paced starts; a one-shot write still measures.
            // Starting as the countdown lands on zero keeps the spacing at
            // exactly one period; testing the registered count costs a cycle.
            if ((st_nxt.ms_left == '0 && !stby) ||                // RULE20
                (reg_wr && reg_addr == `A_ONE_SHOT)) begin
               st_nxt.conv_start = 1'b1;
               st_nxt.conv       = CONV_RUN;
               st_nxt.ms_left    = period_ms(st_r.rate);          // RULE1 RULE2
               st_nxt.tick       = '0;
            end
         end
         CONV_RUN: begin
            // Results land when the front end reports completion
            if (meas_done) begin
               st_nxt.conv     = CONV_IDLE;
               st_nxt.local_t  = meas_local;
               {st_nxt.rmt_hi, st_nxt.rmt_lo[7:6]} =
                  meas_remote + {st_r.ofs_hi, st_r.ofs_lo[7:6]};  // RULE17
               st_nxt.rmt_lo[5:0] = 6'h00;
               st_nxt.open_now = meas_open;
               st_nxt.eval     = 1'b1;
            end
         end
         default: st_nxt.conv = CONV_IDLE;
      endcase

      // Fault queue: count consecutive out-of-limit results, saturate at 4
      for (int i = 0; i < 5; i++) begin
         if (st_r.eval) begin
            if (cond[i] && st_r.qcnt[i] != 3'd4) begin
               st_nxt.qcnt[i] = st_r.qcnt[i] + 3'd1;              // RULE12
            end else if (!cond[i]) begin
               st_nxt.qcnt[i] = 3'd0;
            end
         end
         // In standby the queue is bypassed so limit edits act at once
         set_vec[i] = cond[i] && (stby || st_nxt.qcnt[i] >= need);
      end

      // Latched flags: a status read clears, a set in the same cycle wins
      if (reg_rd && reg_addr == `A_STATUS) begin
         st_nxt.lflags = set_vec;                                 // RULE9
      end else begin
         st_nxt.lflags = st_r.lflags | set_vec;                   // RULE9
      end

      // Critical comparisons with hysteresis
      if (st_r.local_t > st_r.lcrit) begin
         st_nxt.lcrit_act = 1'b1;                                 // RULE8
      end else if (st_r.local_t <= st_r.lcrit - st_r.hyst) begin
         st_nxt.lcrit_act = 1'b0;
      end
      if (st_r.rmt_hi > st_r.rcrit) begin
         st_nxt.rcrit_act = 1'b1;                                 // RULE8
      end else if (st_r.rmt_hi <= st_r.rcrit - st_r.hyst) begin
         st_nxt.rcrit_act = 1'b0;
      end
      st_nxt.crit_out = st_nxt.lcrit_act | st_nxt.rcrit_act;

      // Alert from bits 6..2 only; busy and critical bits never feed it
      st_nxt.alert = (|st_nxt.lflags) && !st_nxt.cfg[`CFG_MASK] &&  // RULE4 RULE19
                     !st_nxt.cfg[`CFG_PIN8];
      // Pin 8 is the alert, or a second critical output on high limits
      st_nxt.pin8_low = st_nxt.cfg[`CFG_PIN8] ? (cond[4] | cond[2]) : st_nxt.alert;

      // Bus line watch; the first sync stage feeds only the second
      st_nxt.sync[0] = {st_r.sync[0][0], scl_in};
      st_nxt.sync[1] = {st_r.sync[1][0], sda_in};
      for (int j = 0; j < 2; j++) begin
         if (st_r.sync[j][1] || !(j == 0 ? st_r.scl_to : st_r.sda_to)) begin
            st_nxt.to_cnt[j] = '0;                                // RULE10 RULE11
         end else if (st_r.to_cnt[j] != TIMEOUT_CYCLES) begin
            st_nxt.to_cnt[j] = st_r.to_cnt[j] + 32'd1;
            // One reset pulse per stuck episode
            if (st_r.to_cnt[j] == TIMEOUT_CYCLES - 1) begin
               st_nxt.bus_rst = 1'b1;                             // RULE21
            end
         end
      end

      // Read data, one cycle after the strobe; unmapped reads give zero
      if (reg_rd) begin
         if (reg_addr == `A_LOCAL_T) begin
            st_nxt.rdata = st_r.local_t;                          // RULE14
         end else if (reg_addr == `A_RMT_T_HI) begin
            st_nxt.rdata = st_r.rmt_hi;                           // RULE14
         end else if (reg_addr == `A_STATUS) begin
            st_nxt.rdata = {st_r.conv == CONV_RUN, st_r.lflags,
                            st_r.rcrit_act, st_r.lcrit_act};      // RULE4 RULE8
         end else if (reg_addr == `A_CFG_RD) begin
            st_nxt.rdata = st_r.cfg;
         end else if (reg_addr == `A_RATE_RD) begin
            st_nxt.rdata = {4'h0, st_r.rate};                     // RULE3
         end else if (reg_addr == `A_LHL_RD) begin
            st_nxt.rdata = st_r.lhl;
         end else if (reg_addr == `A_LLL_RD) begin
            st_nxt.rdata = st_r.lll;
         end else if (reg_addr == `A_RHLU_RD) begin
            st_nxt.rdata = st_r.rhlu;
         end else if (reg_addr == `A_RLLU_RD) begin
            st_nxt.rdata = st_r.rllu;
         end else if (reg_addr == `A_RMT_T_LO) begin
            st_nxt.rdata = st_r.rmt_lo;                           // RULE14
         end else if (reg_addr == `A_OFS_HI) begin
            st_nxt.rdata = st_r.ofs_hi;
         end else if (reg_addr == `A_OFS_LO) begin
            st_nxt.rdata = st_r.ofs_lo;
         end else if (reg_addr == `A_RHLL) begin
            st_nxt.rdata = st_r.rhll;
         end else if (reg_addr == `A_RLLL) begin
            st_nxt.rdata = st_r.rlll;
         end else if (reg_addr == `A_RCRIT) begin
            st_nxt.rdata = st_r.rcrit;
         end else if (reg_addr == `A_LCRIT) begin
            st_nxt.rdata = st_r.lcrit;
         end else if (reg_addr == `A_HYST) begin
            st_nxt.rdata = st_r.hyst;
         end else if (reg_addr == `A_CONSEC) begin
            st_nxt.rdata = {st_r.scl_to, st_r.sda_to, 2'b00, st_r.fq}; // RULE13
         end else begin
            st_nxt.rdata = 8'h00;
         end
      end
   end

   // ----------------------------------------------------------------------
   // State register; power-on values come from ST_RESET
   // ----------------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_r <= ST_RESET;                                        // RULE16
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state register
   assign reg_rdata            = st_r.rdata;
   assign conv_start           = st_r.conv_start;
   assign bus_rst              = st_r.bus_rst;
   assign alert_out            = st_r.alert;
   assign pin8_low             = st_r.pin8_low;
   assign critical_temp_output = st_r.crit_out;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   property p_rate_write;
      reg_wr && reg_addr == `A_RATE_WR |=> st_r.rate == $past(reg_wdata[3:0]);
   endproperty
   a_rate_write: assert property (p_rate_write) else $error("rate write lost"); // RULE3

   // A status read just after a start must already report busy
   property p_busy;
      conv_start ##1 (reg_rd && reg_addr == `A_STATUS) |=> reg_rdata[`ST_BUSY];
   endproperty
   a_busy: assert property (p_busy) else $error("busy not set at start"); // RULE4

   property p_alert_cause;
      alert_out |-> (|st_r.lflags) && !st_r.cfg[`CFG_MASK];
   endproperty
   a_alert_cause: assert property (p_alert_cause) else $error("alert without flag"); // RULE19

   property p_status_clear;
      reg_rd && reg_addr == `A_STATUS && set_vec == '0 |=> st_r.lflags == '0;
   endproperty
   a_status_clear: assert property (p_status_clear) else $error("flags not cleared"); // RULE9

   property p_no_timeout;
      !st_r.scl_to && !st_r.sda_to |=> !bus_rst;
   endproperty
   a_no_timeout: assert property (p_no_timeout) else $error("timeout while disabled"); // RULE10

   property p_limit_read_addr;
      reg_wr && reg_addr == `A_LHL_RD |=> st_r.lhl == $past(st_r.lhl);
   endproperty
   a_limit_read_addr: assert property (p_limit_read_addr) else $error("write at read addr"); // RULE15

   property p_result_ro;
      reg_wr && reg_addr == `A_LOCAL_T && !meas_done |=> st_r.local_t == $past(st_r.local_t);
   endproperty
   a_result_ro: assert property (p_result_ro) else $error("result register written"); // RULE14

   property p_standby;
      st_r.cfg[`CFG_STBY] && !(reg_wr && reg_addr == `A_ONE_SHOT) |=> !conv_start;
   endproperty
   a_standby: assert property (p_standby) else $error("conversion in standby"); // RULE20

   property p_hyst_readback;
      reg_wr && reg_addr == `A_HYST ##1 reg_rd && reg_addr == `A_HYST
         |=> reg_rdata == $past(reg_wdata, 2);
   endproperty
   a_hyst_readback: assert property (p_hyst_readback) else $error("hysteresis readback"); // RULE18

endmodule : temp_monitor_regs

// *** bench/fe_model.sv ***
// Front end model: answers each conversion start after a set latency
`timescale 1ns/10ps
module fe_model (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // Conversion link
   input  wire logic       conv_start,
   output logic            meas_done,
   output logic      [7:0] meas_local,
   output logic      [9:0] meas_remote,
   output logic            meas_open,
   // Readings and latency chosen by the bench
   input  wire logic [7:0] lv,
   input  wire logic [9:0] rv,
   input  wire logic       ov,
   input  wire logic [3:0] lat
);
   logic [4:0] cnt_r;  // Cycles to the answer, 0 when idle
   // Latency counter, restarted by every start
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt_r     <= 5'h00;
         meas_done <= 1'b0;
      end else begin
         meas_done <= (cnt_r == 5'h01);
         if (conv_start)
            cnt_r <= {1'b0, lat} + 5'h01;
         else if (cnt_r != 5'h00)
            cnt_r <= cnt_r - 5'h01;
      end
   end
   // Garbled outside the pulse so a stale sample cannot pass
   assign meas_local  = meas_done ? lv : ~lv;
   assign meas_remote = meas_done ? rv : ~rv;
   assign meas_open   = meas_done ? ov : ~ov;
endmodule : fe_model

// *** bench/tb_top.sv ***
// Self-checking bench for the temperature monitor register bank
`timescale 1ns/10ps
module tb_top;
   logic       mclk, rst, reg_wr, reg_rd, rd_d, scl_in, sda_in, ov, conv_start, meas_done;
   logic       meas_open, bus_rst, alert_out, pin8_low, critical_temp_output;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, lv, meas_local, r, e;
   logic [9:0] rv, meas_remote;
   logic [3:0] lat;
   logic [7:0] expq[$];  // Expected read data, oldest first
   int         failures, comparisons, cyc, nrst, last_st, gap, seed, n0;
   // Power-on table: addresses and values
   logic [7:0] ra[17] = '{8'h00, 8'h01, 8'h10, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h11,
                          8'h12, 8'h13, 8'h14, 8'h19, 8'h20, 8'h21, 8'h22, 8'h30};
   logic [7:0] rx[17] = '{8'h00, 8'h00, 8'h00, 8'h06, 8'h55, 8'h00, 8'h55, 8'h00, 8'h00,
                          8'h00, 8'h00, 8'h00, 8'h55, 8'h55, 8'h0A, 8'h01, 8'h00};
   // Short counts keep the run brief
   temp_monitor_regs #(.CYC_PER_MS(4), .TIMEOUT_CYCLES(20)) dut (.mclk, .rst, .reg_addr,
      .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .conv_start, .meas_done, .meas_local,
      .meas_remote, .meas_open, .scl_in, .sda_in, .bus_rst, .alert_out, .pin8_low,
      .critical_temp_output);
   fe_model fe (.mclk, .rst, .conv_start, .meas_done, .meas_local, .meas_remote,
      .meas_open, .lv, .rv, .ov, .lat);
   // 50 MHz clock
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Idle wait; strobes drop here, so back-to-back transfers keep them up
   task automatic tick(input int n);
      {reg_wr, reg_rd} = 2'b00;
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      {reg_wr, reg_rd} = 2'b10;
      reg_addr         = a;
      reg_wdata        = d;
      @(posedge mclk);
      #1;
   endtask : wr
   // Read strobe; the expected byte waits in the queue
   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      {reg_wr, reg_rd} = 2'b01;
      reg_addr         = a;
      expq.push_back(x);
      @(posedge mclk);
      #1;
   endtask : rd
   // Bounded wait for the answer, then let the flags settle
   task automatic wdone();
      for (int n = 0; n < 300 && meas_done !== 1'b1; n++) tick(1);
      tick(3);
   endtask : wdone
   task automatic conv(input logic [7:0] l, input logic [7:0] rh, input logic o);
      lv = l;
      rv = {rh, 2'b00};
      ov = o;
      wr(8'h0F, 8'h00);
      wdone();
   endtask : conv
   task automatic close_out();
      $display("failures=%0d comparisons=%0d", failures, comparisons);
      if (failures == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : close_out
   // Pulse counting and start spacing
   always @(posedge mclk) begin
      rd_d <= reg_rd;
      if (bus_rst === 1'b1) nrst++;
      if (conv_start === 1'b1) begin
         gap = cyc - last_st;
         last_st = cyc;
      end
   end
   // Read data compared mid-cycle, clear of the edge; hang guard
   always @(negedge mclk) begin
      cyc++;
      if (rd_d === 1'b1) begin
         e = expq.pop_front();
         chk(reg_rdata, e);
      end
      if (cyc == 5000) begin
         failures++;
         close_out();
      end
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      seed = 32'h024B4BAA;
      {rst, reg_wr, reg_rd, ov} = 4'b1000;
      {scl_in, sda_in, reg_addr, reg_wdata, lv, rv, lat} = {2'b11, 34'h0, 4'h2};
      tick(6);
      rst = 1'b0;
      tick(2);
      foreach (ra[n]) rd(ra[n], rx[n]);
      wr(8'h09, 8'h40);
      r = 8'($random(seed));
      r[3:0] = r[3:0] % 4'hB;
      wr(8'h0A, r);
      wr(8'h04, 8'h0F);
      rd(8'h04, {4'h0, r[3:0]});
      wr(8'h0B, 8'h40);
      wr(8'h05, 8'hEE);
      rd(8'h05, 8'h40);
      wr(8'h22, 8'hFF);
      rd(8'h22, 8'hCF);
      wr(8'h22, 8'h02);
      wr(8'h11, r);
      rd(8'h11, r);
      wr(8'h11, 8'h00);
      wr(8'h21, r);
      rd(8'h21, r);
      wr(8'h21, 8'h0A);
      wr(8'h00, 8'hA5);
      rd(8'h00, 8'h00);
      // Busy seen during a slow answer
      lat = 4'h6;
      lv = 8'h30;
      rv = {8'h20, 2'b00};
      wr(8'h0F, 8'h00);
      tick(1);
      rd(8'h02, 8'h80);
      wdone();
      rd(8'h02, 8'h00);
      lat = 4'h2;
      wr(8'h0C, 8'h10);
      wr(8'h0E, 8'h10);
      conv(8'h48, 8'h20, 1'b0);
      chk({7'h00, alert_out}, 8'h01);
      chk({7'h00, pin8_low}, 8'h01);
      conv(8'h08, 8'h08, 1'b0);
      conv(8'h30, 8'h20, 1'b1);
      conv(8'h30, 8'h20, 1'b0);
      rd(8'h00, 8'h30);
      rd(8'h02, 8'h6C);
      rd(8'h02, 8'h00);
      tick(2);
      chk({7'h00, alert_out}, 8'h00);
      conv(8'h60, 8'h60, 1'b0);
      rd(8'h02, 8'h53);
      chk({7'h00, critical_temp_output}, 8'h01);
      wr(8'h09, 8'hC0);
      tick(2);
      chk({7'h00, alert_out}, 8'h00);
      wr(8'h09, 8'h40);
      tick(2);
      chk({7'h00, alert_out}, 8'h01);
      wr(8'h09, 8'h60);
      tick(2);
      chk({6'h00, alert_out, pin8_low}, 8'h01);
      wr(8'h09, 8'h40);
      conv(8'h30, 8'h20, 1'b0);
      rd(8'h02, 8'h50);
      rd(8'h02, 8'h00);
      chk({7'h00, critical_temp_output}, 8'h00);
      // Running mode: fastest rate, two readings needed
      wr(8'h0A, 8'h0A);
      // A one-shot reloads the countdown with the new rate's period
      conv(8'h30, 8'h20, 1'b0);
      lv = 8'h48;
      wr(8'h09, 8'h00);
      wdone();
      rd(8'h02, 8'h00);
      wdone();
      rd(8'h02, 8'h40);
      chk(gap[7:0], 8'h6C);
      // Each line held low under each enable pattern
      for (int k = 0; k < 4; k++) begin
         wr(8'h22, {k[1:0], 6'h02});
         for (int j = 0; j < 2; j++) begin
            n0 = nrst;
            {scl_in, sda_in} = j[0] ? 2'b10 : 2'b01;
            tick(30);
            {scl_in, sda_in} = 2'b11;
            tick(4);
            chk(8'(nrst - n0), {7'h00, k[1 - j]});
         end
      end
      close_out();
   end
endmodule : tb_top
